// >>> hw/uart_top.sv
// Serial port top: APB registers, transmitter, flags, interrupt
// Assumes an APB master and pins synchronous to clock
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "uart_consts.svh"

module uart_top (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        reset_n,
   input  wire logic        ce,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic             pslverr,
   output logic [31:0]      prdata,
   // Serial line
   input  wire logic        rxd,
   output logic             txd,
   // Timer clock inputs
   input  wire logic        extOscClk,
   input  wire logic        timerExtPin,
   // Interrupt
   output logic             irq
);
   // Register state
   logic [7:0]  ctl_r;
   logic [3:0]  tctl_r;
   logic [7:0]  reload_r;
   logic [1:0]  status_r;
   logic [1:0]  ien_r;
   logic [7:0]  rxBuf_r;
   logic [31:0] prdata_r;
   logic        armed_r;

   // Transmitter state
   uart_pkg::tx_state_t txState_r;
   logic [8:0]  txShift_r;
   logic [2:0]  txCnt_r;
   logic        txd_r;

   // Internal nets
   uart_pkg::timer_cfg_t tmrCfg;
   uart_pkg::rx_frame_t  rxFrame;
   logic [31:0] rdVal;
   logic        mapped;
   logic        wrAcc;
   logic        rxLoad;
   logic        txEvt;
   logic        txBaudTick;
   logic        rxOvf;
   logic        startDet;
   logic [7:0]  tlow;
   logic [1:0]  events;
   logic [1:0]  clrMask;
   logic        mode9;

   // Write strobe for one register
   function automatic logic wrTo(input logic [7:0] a);
      return wrAcc && (paddr == a);
   endfunction

   // APB handshake
   assign pready  = psel && penable && armed_r && ce;
   assign pslverr = pready && !mapped;
   assign prdata  = prdata_r;
   assign wrAcc   = pready && pwrite && mapped;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         armed_r <= 1'b0;
      end else if (ce) begin
         if (psel && !penable) armed_r <= 1'b1;
         else if (pready) armed_r <= 1'b0;
      end
   end

   // Read data is sampled in the setup cycle
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (ce) begin
         if (psel && !penable && !pwrite) prdata_r <= rdVal;
      end
   end

   // Read decode
   always_comb begin
      rdVal  = 32'h0000_0000;
      mapped = 1'b1;
      if (paddr == `ADDR_CTRL) begin
         rdVal[7:0] = ctl_r | `CTL_FIXED;
      end else if (paddr == `ADDR_DATA) begin
         rdVal[7:0] = rxBuf_r;
      end else if (paddr == `ADDR_TCTL) begin
         rdVal[3:0] = tctl_r;
      end else if (paddr == `ADDR_RELOAD) begin
         rdVal[7:0] = reload_r;
      end else if (paddr == `ADDR_TLOW) begin
         rdVal[7:0] = tlow;
      end else if (paddr == `ADDR_STAT) begin
         rdVal[1:0] = status_r;
      end else if (paddr == `ADDR_CLR) begin
         rdVal[1:0] = 2'h0;
      end else if (paddr == `ADDR_IEN) begin
         rdVal[1:0] = ien_r;
      end else begin
         mapped = 1'b0;
      end
   end

   // Mode and receive acceptance
   assign mode9  = ctl_r[`CTL_MODE];
   assign rxLoad = rxFrame.valid && !ctl_r[`CTL_RI]
                   && (!ctl_r[`CTL_MPE] || rxFrame.ninth);
   assign txEvt  = (txState_r == uart_pkg::TX_STOP) && txBaudTick;

   // Control register with hardware-set flags
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         ctl_r <= `CTL_RESET;
      end else if (ce) begin
         if (wrTo(`ADDR_CTRL)) ctl_r <= pwdata[7:0];
         if (rxLoad) begin
            ctl_r[`CTL_RB8] <= rxFrame.ninth;
            ctl_r[`CTL_RI]  <= 1'b1;
         end
         if (txEvt) ctl_r[`CTL_TI] <= 1'b1;
      end
   end

   // Receive buffer, written only by an accepted frame
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rxBuf_r <= 8'h00;
      end else if (ce) begin
         if (rxLoad) rxBuf_r <= rxFrame.data;
      end
   end

   // Timer configuration registers
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tctl_r   <= 4'h0;
         reload_r <= 8'h00;
      end else if (ce) begin
         if (wrTo(`ADDR_TCTL)) tctl_r <= pwdata[3:0];
         if (wrTo(`ADDR_RELOAD)) reload_r <= pwdata[7:0];
      end
   end

   always_comb begin
      tmrCfg.run    = tctl_r[`TCTL_RUN];
      tmrCfg.src    = tctl_r[`TCTL_SRC_HI:`TCTL_SRC_LO];
      tmrCfg.reload = reload_r;
   end

   // Sticky status, clear and enable
   assign events  = {txEvt, rxLoad};
   assign clrMask = wrTo(`ADDR_CLR) ? pwdata[1:0] : 2'h0;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         status_r <= 2'h0;
         ien_r    <= 2'h0;
      end else if (ce) begin
         status_r <= (status_r & ~clrMask) | events;
         if (wrTo(`ADDR_IEN)) ien_r <= pwdata[1:0];
      end
   end

   assign irq = |(status_r & ien_r);

   // Transmitter
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         txState_r <= uart_pkg::TX_IDLE;
         txShift_r <= 9'h000;
         txCnt_r   <= 3'h0;
         txd_r     <= 1'b1;
      end else if (ce) begin
         if (wrTo(`ADDR_DATA)) begin
            txShift_r <= {ctl_r[`CTL_TB8], pwdata[7:0]};
            txState_r <= uart_pkg::TX_START;
         end else if (txBaudTick) begin
            case (txState_r)
               uart_pkg::TX_IDLE: begin
                  txd_r <= 1'b1;
               end
               uart_pkg::TX_START: begin
                  txd_r     <= 1'b0;
                  txCnt_r   <= 3'h0;
                  txState_r <= uart_pkg::TX_DATA;
               end
               uart_pkg::TX_DATA: begin
                  txd_r     <= txShift_r[0];
                  txShift_r <= {1'b0, txShift_r[8:1]};
                  txCnt_r   <= txCnt_r + 3'h1;
                  if (txCnt_r == `BIT_LAST)
                     txState_r <= mode9 ? uart_pkg::TX_NINTH : uart_pkg::TX_STOP;
               end
               uart_pkg::TX_NINTH: begin
                  txd_r     <= txShift_r[0];
                  txState_r <= uart_pkg::TX_STOP;
               end
               uart_pkg::TX_STOP: begin
                  txd_r     <= 1'b1;
                  txState_r <= uart_pkg::TX_IDLE;
               end
               default: begin
                  txState_r <= uart_pkg::TX_IDLE;
               end
            endcase
         end
      end
   end

   assign txd = txd_r;

   // Baud timer
   baud_timer timer_i (
      .clock       (clock),
      .reset_n     (reset_n),
      .ce          (ce),
      .cfg         (tmrCfg),
      .tlowWr      (wrTo(`ADDR_TLOW)),
      .tlowData    (pwdata[7:0]),
      .tlow        (tlow),
      .extOscClk   (extOscClk),
      .timerExtPin (timerExtPin),
      .rxReload    (startDet),
      .txBaudTick  (txBaudTick),
      .rxOvf       (rxOvf)
   );

   // Receiver
   serial_rx rx_i (
      .clock    (clock),
      .reset_n  (reset_n),
      .ce       (ce),
      .rxd      (rxd),
      .enable   (ctl_r[`CTL_REN]),
      .mode9    (mode9),
      .rxOvf    (rxOvf),
      .startDet (startDet),
      .frame    (rxFrame)
   );

   // Checks
   default clocking cb @(posedge clock iff ce); endclocking
   default disable iff (!reset_n);

   sequence dataWrite;
      pready && pwrite && (paddr == `ADDR_DATA);
   endsequence

   sequence startBitOut;
      (txState_r == uart_pkg::TX_START) && txBaudTick && !wrTo(`ADDR_DATA);
   endsequence

   sequence stopBitOut;
      (txState_r == uart_pkg::TX_STOP) && txBaudTick && !wrTo(`ADDR_DATA);
   endsequence

   data_read_a: assert property (pready && !pwrite && (paddr == `ADDR_DATA)
                                 |-> prdata == {24'h00_0000, $past(rxBuf_r)})
      else $error("Data read did not return receive buffer");

   tx_start_a: assert property (dataWrite |=> txState_r == uart_pkg::TX_START)
      else $error("Data write did not start transmission");

   start_bit_a: assert property (startBitOut |=> !txd_r
                                 && txState_r == uart_pkg::TX_DATA)
      else $error("Start bit not driven low");

   tx_flag_a: assert property (stopBitOut |=> ctl_r[`CTL_TI] && txd_r
                               && status_r[`EV_TX])
      else $error("Transmit flag not set at stop bit");

   rx_load_a: assert property (rxLoad |=> ctl_r[`CTL_RI]
                               && rxBuf_r == $past(rxFrame.data))
      else $error("Accepted frame not loaded");

   rx_block_a: assert property (rxFrame.valid && ctl_r[`CTL_RI]
                                |=> $stable(rxBuf_r))
      else $error("Frame loaded over a set flag");

   mp_filter_a: assert property (rxFrame.valid && ctl_r[`CTL_MPE] && !rxFrame.ninth
                                 |-> !rxLoad)
      else $error("Multiprocessor filter let a data byte through");

   flag_hold_a: assert property (ctl_r[`CTL_RI] && !wrTo(`ADDR_CTRL)
                                 |=> ctl_r[`CTL_RI])
      else $error("Receive flag cleared without software");

   irq_rx_a: assert property (rxLoad && ien_r[`EV_RX] |=> irq)
      else $error("Receive event did not raise interrupt");

   stop_len_a: assert property (stopBitOut |=> txd_r [*2])
      else $error("Stop bit too short");
endmodule // uart_top

`default_nettype wire

// >>> hw/uart_consts.svh
// Constants for the serial port with timer baud generator
// Assumes an APB master and one 10 MHz clock domain
// How it works
// - 8-bit or 9-bit variable-rate full duplex
// - receive shifter separate from receive buffer
// - data write loads transmitter and starts
// - data read returns receive buffer only
// - enabled flags raise the interrupt
// - flags cleared only by software
// - transmit clock from 8-bit auto-reload timer
// - hidden receive timer shares reload byte
// - each timer overflow divided by two
// - start edge reloads the receive timer
// - six selectable timer clock sources
// - overflow every 256 minus reload ticks
// - 8-bit frame: start, 8 LSB-first, stop
// - 9-bit frame adds programmable ninth bit
// - tx flag at stop start; receive needs enable
// - load only if flag clear, multiprocessor check
`ifndef UART_CONSTS_SVH
`define UART_CONSTS_SVH

// Register byte addresses
`define ADDR_CTRL   8'h00
`define ADDR_DATA   8'h04
`define ADDR_TCTL   8'h08
`define ADDR_RELOAD 8'h0C
`define ADDR_TLOW   8'h10
`define ADDR_STAT   8'h14
`define ADDR_CLR    8'h18
`define ADDR_IEN    8'h1C

// Control register fields
`define CTL_FIXED   8'h40
`define CTL_RESET   `CTL_FIXED
`define CTL_MODE    7
`define CTL_MPE     5
`define CTL_REN     4
`define CTL_TB8     3
`define CTL_RB8     2
`define CTL_TI      1
`define CTL_RI      0

// Event bits of status, clear and enable
`define EV_RX       0
`define EV_TX       1

// Timer control fields and sources
`define TCTL_RUN    0
`define TCTL_SRC_HI 3
`define TCTL_SRC_LO 1
`define SRC_SYS     3'h0
`define SRC_DIV4    3'h1
`define SRC_DIV12   3'h2
`define SRC_DIV48   3'h3
`define SRC_OSC8    3'h4
`define SRC_PIN     3'h5

// Prescaler and counter limits
`define PRE_LAST    6'h2F
`define PRE_D4      2'h3
`define PRE_D12_A   6'h0B
`define PRE_D12_B   6'h17
`define PRE_D12_C   6'h23
`define OSC_LAST    3'h7
`define TMR_TOP     8'hFF
`define BIT_LAST    3'h7

`endif

// >>> hw/uart_pkg.sv
// Types shared by the serial port modules
// Assumes the constants header is included by each user
package uart_pkg;
   typedef enum logic [4:0] {
      TX_IDLE  = 5'h01,
      TX_START = 5'h02,
      TX_DATA  = 5'h04,
      TX_NINTH = 5'h08,
      TX_STOP  = 5'h10
   } tx_state_t;

   typedef enum logic [4:0] {
      RX_IDLE  = 5'h01,
      RX_START = 5'h02,
      RX_DATA  = 5'h04,
      RX_NINTH = 5'h08,
      RX_STOP  = 5'h10
   } rx_state_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       ninth;
   } rx_frame_t;

   typedef struct packed {
      logic       run;
      logic [2:0] src;
      logic [7:0] reload;
   } timer_cfg_t;
endpackage

// >>> hw/baud_timer.sv
// Baud timer: prescaler, visible low byte and hidden receive copy
// Assumes external inputs are synchronous to clock
`timescale 1ns/10ps
`default_nettype none
`include "uart_consts.svh"

module baud_timer (
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                reset_n,
   input  wire logic                ce,
   // Configuration and software access
   input  wire uart_pkg::timer_cfg_t cfg,
   input  wire logic                tlowWr,
   input  wire logic [7:0]          tlowData,
   output logic [7:0]               tlow,
   // External clock sources
   input  wire logic                extOscClk,
   input  wire logic                timerExtPin,
   // Receive reload input and baud outputs
   input  wire logic                rxReload,
   output logic                     txBaudTick,
   output logic                     rxOvf
);
   logic [5:0] preCnt_r;
   logic [2:0] oscCnt_r;
   logic       oscPrev_r;
   logic       pinPrev_r;
   logic [7:0] tlow_r;
   logic [7:0] rxTmr_r;
   logic       txHalf_r;
   logic       tick;
   logic       txOvf;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         preCnt_r  <= 6'h00;
         oscCnt_r  <= 3'h0;
         oscPrev_r <= 1'b0;
         pinPrev_r <= 1'b0;
      end else if (ce) begin
         preCnt_r  <= (preCnt_r == `PRE_LAST) ? 6'h00 : preCnt_r + 6'h01;
         oscPrev_r <= extOscClk;
         pinPrev_r <= timerExtPin;
         if (extOscClk && !oscPrev_r) oscCnt_r <= oscCnt_r + 3'h1;
      end
   end

   always_comb begin
      case (cfg.src)
         `SRC_SYS:   tick = 1'b1;
         `SRC_DIV4:  tick = (preCnt_r[1:0] == `PRE_D4);
         `SRC_DIV12: tick = (preCnt_r == `PRE_D12_A) || (preCnt_r == `PRE_D12_B)
                            || (preCnt_r == `PRE_D12_C) || (preCnt_r == `PRE_LAST);
         `SRC_DIV48: tick = (preCnt_r == `PRE_LAST);
         `SRC_OSC8:  tick = extOscClk && !oscPrev_r && (oscCnt_r == `OSC_LAST);
         `SRC_PIN:   tick = timerExtPin && !pinPrev_r;
         default:    tick = 1'b0;
      endcase
   end

   assign txOvf      = cfg.run && tick && (tlow_r == `TMR_TOP);
   assign rxOvf      = cfg.run && tick && (rxTmr_r == `TMR_TOP) && !rxReload;
   assign txBaudTick = txOvf && txHalf_r;
   assign tlow       = tlow_r;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tlow_r   <= 8'h00;
         txHalf_r <= 1'b0;
      end else if (ce) begin
         if (tlowWr) tlow_r <= tlowData;
         else if (cfg.run && tick) tlow_r <= txOvf ? cfg.reload : tlow_r + 8'h01;
         if (txOvf) txHalf_r <= !txHalf_r;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rxTmr_r <= 8'h00;
      end else if (ce) begin
         if (rxReload) rxTmr_r <= cfg.reload;
         else if (cfg.run && tick) rxTmr_r <= (rxTmr_r == `TMR_TOP) ? cfg.reload
                                                 : rxTmr_r + 8'h01;
      end
   end

   default clocking cb @(posedge clock iff ce); endclocking
   default disable iff (!reset_n);

   rx_reload_a: assert property (rxReload |=> rxTmr_r == $past(cfg.reload))
      else $error("Receive timer not reloaded on start");
   baud_half_a: assert property (txOvf |=> txHalf_r != $past(txHalf_r))
      else $error("Transmit overflow halving broken");
   baud_tick_a: assert property (txBaudTick |-> !$past(txBaudTick))
      else $error("Transmit baud tick not every second overflow");
endmodule // baud_timer

`default_nettype wire

// >>> hw/serial_rx.sv
// Receive shifter: start detect, mid-bit sampling, frame output
// Assumes rxOvf pulses at twice the bit rate
`timescale 1ns/10ps
`default_nettype none
`include "uart_consts.svh"

module serial_rx (
   // Clock and reset
   input  wire logic               clock,
   input  wire logic               reset_n,
   input  wire logic               ce,
   // Line and control
   input  wire logic               rxd,
   input  wire logic               enable,
   input  wire logic               mode9,
   input  wire logic               rxOvf,
   // Results
   output logic                    startDet,
   output uart_pkg::rx_frame_t     frame
);
   uart_pkg::rx_state_t st_r;
   uart_pkg::rx_frame_t frame_r;
   logic       rxdPrev_r;
   logic       phase_r;
   logic [2:0] cnt_r;
   logic [7:0] shift_r;
   logic       ninth_r;
   logic       sample;

   assign startDet = (st_r == uart_pkg::RX_IDLE) && enable && rxdPrev_r && !rxd;
   assign sample   = rxOvf && !phase_r;
   assign frame    = frame_r;

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rxdPrev_r <= 1'b1;
         phase_r   <= 1'b0;
      end else if (ce) begin
         rxdPrev_r <= rxd;
         if (startDet) phase_r <= 1'b0;
         else if (rxOvf) phase_r <= !phase_r;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         st_r    <= uart_pkg::RX_IDLE;
         cnt_r   <= 3'h0;
         shift_r <= 8'h00;
         ninth_r <= 1'b0;
         frame_r <= '0;
      end else if (ce) begin
         frame_r.valid <= 1'b0;
         case (st_r)
            uart_pkg::RX_IDLE: begin
               if (startDet) st_r <= uart_pkg::RX_START;
            end
            uart_pkg::RX_START: begin
               if (sample) begin
                  st_r  <= rxd ? uart_pkg::RX_IDLE : uart_pkg::RX_DATA;
                  cnt_r <= 3'h0;
               end
            end
            uart_pkg::RX_DATA: begin
               if (sample) begin
                  shift_r <= {rxd, shift_r[7:1]};
                  cnt_r   <= cnt_r + 3'h1;
                  if (cnt_r == `BIT_LAST)
                     st_r <= mode9 ? uart_pkg::RX_NINTH : uart_pkg::RX_STOP;
               end
            end
            uart_pkg::RX_NINTH: begin
               if (sample) begin
                  ninth_r <= rxd;
                  st_r    <= uart_pkg::RX_STOP;
               end
            end
            uart_pkg::RX_STOP: begin
               if (sample) begin
                  st_r          <= uart_pkg::RX_IDLE;
                  frame_r.valid <= 1'b1;
                  frame_r.data  <= shift_r;
                  frame_r.ninth <= mode9 ? ninth_r : rxd;
               end
            end
            default: st_r <= uart_pkg::RX_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge clock iff ce); endclocking
   default disable iff (!reset_n);

   rx_enable_a: assert property (st_r == uart_pkg::RX_IDLE ##1 st_r != uart_pkg::RX_IDLE
                                 |-> $past(enable))
      else $error("Reception started while disabled");
endmodule // serial_rx

`default_nettype wire

// >>> dv/remote_serial.sv
// Remote serial device: sends frames on its line, captures frames
// Assumes line idles high and a bit lasts a whole number of clocks
`timescale 1ns/10ps
`default_nettype none

module remote_serial (
   // Clock
   input  wire logic clock,
   // Serial line
   input  wire logic serialIn,
   output logic      serialOut
);
   initial serialOut = 1'b1;

   // Start low, data LSB first, optional ninth, stop high
   task automatic sendFrame(input logic [7:0] d, input logic n9, input logic m9,
                            input int w);
      logic [10:0] bits;
      @(posedge clock);
      bits = m9 ? {1'b1, n9, d, 1'b0} : {2'b11, d, 1'b0};
      for (int i = 0; i < 10 + m9; i++) begin
         serialOut <= bits[i];
         repeat (w) @(posedge clock);
      end
   endtask

   // Measure start width, then sample mid-bit; bit 0 must be 1
   task automatic getFrame(input logic m9, output logic [9:0] got, output int w);
      int n;
      n = 0;
      w = 0;
      got = '0;
      while (serialIn !== 1'b0 && n < 5000) begin
         @(posedge clock);
         n++;
      end
      while (serialIn === 1'b0 && w < 500) begin
         @(posedge clock);
         w++;
      end
      got[0] = serialIn;
      repeat (w / 2) @(posedge clock);
      for (int i = 1; i < 9 + m9; i++) begin
         repeat (w) @(posedge clock);
         got[i] = serialIn;
      end
   endtask
endmodule // remote_serial

`default_nettype wire

// >>> dv/testbench.sv
// Testbench: APB register tasks, remote device, sequences with expectations
// Assumes the register map of the constants header and a 10 MHz clock
`timescale 1ns/10ps
`default_nettype none
`include "uart_consts.svh"

module testbench;
   logic        clock = 1'b0;
   logic        reset_n = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        pready, pslverr, txd, irq;
   logic [31:0] prdata;
   wire         rxd;
   logic        extOscClk = 1'b0;
   logic        timerExtPin = 1'b0;
   int          n_mismatch = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [31:0] rd;
   logic        err;
   logic [9:0]  fr;
   int          w;
   int          widths [6] = '{2, 8, 24, 96, 32, 4};

   uart_top u_uart_top (.clock, .reset_n, .ce(1'b1), .psel, .penable, .pwrite, .paddr,
      .pwdata, .pready, .pslverr, .prdata, .rxd, .txd, .extOscClk, .timerExtPin, .irq);
   remote_serial remote (.clock(clock), .serialIn(txd), .serialOut(rxd));

   always #50 clock = ~clock;
   always @(posedge clock) begin
      extOscClk <= ~extOscClk;
      timerExtPin <= ~timerExtPin;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         give_verdict();
      end
   end

   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One APB transfer: setup, access until pready, then release
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(negedge clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) n_mismatch++;
      rd = prdata;
      err = pslverr;
      @(posedge clock);
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge clock);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      cmp(what, exp, rd);
   endtask

   task automatic waitIrq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         @(posedge clock);
         n++;
      end
      cmp("irq", 32'h1, 32'(irq));
   endtask

   task automatic give_verdict();
      $display("Mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      // Reset values, read-only status, unmapped place
      for (int a = 0; a < 32; a += 4) begin
         rdChk("reset value", 8'(a), a == 0 ? 32'h00000040 : 32'h0);
      end
      wr(`ADDR_STAT, 32'h3);
      rdChk("status", `ADDR_STAT, 32'h0);
      rdChk("unmapped", 8'h20, 32'h0);
      cmp("slverr", 32'h1, 32'(err));
      wr(`ADDR_TCTL, 32'h1);
      wr(`ADDR_RELOAD, 32'hFE);
      wr(`ADDR_IEN, 32'h3);
      wr(`ADDR_CTRL, 32'h10);
      // Transmit 8-bit, flag, interrupt masking, software clear
      wr(`ADDR_DATA, 32'hA5);
      remote.getFrame(1'b0, fr, w);
      cmp("tx frame", 32'h1A5, 32'(fr[8:0]));
      cmp("bit width", 32'd4, 32'(w));
      waitIrq();
      rdChk("ctrl", `ADDR_CTRL, 32'h52);
      wr(`ADDR_IEN, 32'h0);
      cmp("irq masked", 32'h0, 32'(irq));
      wr(`ADDR_IEN, 32'h3);
      rdChk("status", `ADDR_STAT, 32'h2);
      cmp("irq kept", 32'h1, 32'(irq));
      wr(`ADDR_CLR, 32'h2);
      wr(`ADDR_CTRL, 32'h10);
      rdChk("status", `ADDR_STAT, 32'h0);
      cmp("irq clear", 32'h0, 32'(irq));
      // Receive 8-bit, then refuse a frame while the flag stands
      remote.sendFrame(8'h3C, 1'b0, 1'b0, 4);
      waitIrq();
      rdChk("rx data", `ADDR_DATA, 32'h3C);
      rdChk("ctrl", `ADDR_CTRL, 32'h55);
      remote.sendFrame(8'h81, 1'b0, 1'b0, 4);
      repeat (8) @(posedge clock);
      rdChk("overrun", `ADDR_DATA, 32'h3C);
      // 9-bit with multiprocessor filter
      wr(`ADDR_CLR, 32'h1);
      wr(`ADDR_CTRL, 32'hB0);
      remote.sendFrame(8'h11, 1'b0, 1'b1, 4);
      repeat (8) @(posedge clock);
      rdChk("filtered", `ADDR_STAT, 32'h0);
      remote.sendFrame(8'h22, 1'b1, 1'b1, 4);
      waitIrq();
      rdChk("rx data", `ADDR_DATA, 32'h22);
      rdChk("ctrl", `ADDR_CTRL, 32'hF5);
      // Second byte arrives while the first is still buffered
      wr(`ADDR_CLR, 32'h1);
      wr(`ADDR_CTRL, 32'h90);
      fork
         remote.sendFrame(8'h33, 1'b0, 1'b1, 4);
         begin
            repeat (20) @(posedge clock);
            rdChk("held data", `ADDR_DATA, 32'h22);
         end
      join
      waitIrq();
      rdChk("rx data", `ADDR_DATA, 32'h33);
      rdChk("ctrl", `ADDR_CTRL, 32'hD1);
      // Transmit 9-bit with programmed ninth bit
      wr(`ADDR_CTRL, 32'h98);
      wr(`ADDR_DATA, 32'h5B);
      remote.getFrame(1'b1, fr, w);
      cmp("tx frame9", 32'h35B, 32'(fr));
      // Every timer clock source with reload at its top value
      wr(`ADDR_CTRL, 32'h10);
      wr(`ADDR_RELOAD, 32'hFF);
      for (int s = 0; s < 6; s++) begin
         wr(`ADDR_TCTL, 32'((s << 1) | 1));
         wr(`ADDR_DATA, 32'h55);
         remote.getFrame(1'b0, fr, w);
         cmp("src width", 32'(widths[s]), 32'(w));
         cmp("src frame", 32'h155, 32'(fr[8:0]));
      end
      wr(`ADDR_TCTL, 32'h0);
      wr(`ADDR_TLOW, 32'h5A);
      rdChk("timer low", `ADDR_TLOW, 32'h5A);
      give_verdict();
   end
endmodule // testbench

`default_nettype wire
